// File: core/twbo_cfg.svh
`ifndef TWBO_CFG_SVH
`define TWBO_CFG_SVH

// external master address and size field layout
`define TWBO_ADDR_W      28
`define TWBO_UPPER_MSB   27
`define TWBO_UPPER_LSB   24
`define TWBO_REGION_LSB  16
`define TWBO_REGION_W    12
`define TWBO_SIZE_W      2

// size encodings on the transfer_size pins
`define TWBO_SZ_LONG     2'h0
`define TWBO_SZ_BYTE     2'h1
`define TWBO_SZ_WORD     2'h2
`define TWBO_SZ_LINE     2'h3

// counts and widths
`define TWBO_WS_W        4
`define TWBO_NUM_CS      8
`define TWBO_NUM_DRAM    2
`define TWBO_NUM_LANES   4
`define TWBO_DRAM_ADDR_W 14
`define TWBO_ROW_LSB     14
`define TWBO_COL_LSB     0
`define TWBO_DRAM_WAIT   4'h2
`define TWBO_RCD_CYCLES  4'h1

// reset values
`define TWBO_UPPER_ZERO  4'h0
`define TWBO_WS_RESET    4'h0

`endif

// File: core/twbo_pkg.sv
`include "twbo_cfg.svh"

package twbo_pkg;

  // arbitration states
  typedef enum logic [1:0] {
    TWBO_RESET,
    TWBO_IMPLICIT,
    TWBO_EXPLICIT,
    TWBO_EM_OWN
  } twbo_arb_e;

  // alternate master access sequence
  typedef enum logic [1:0] {
    TWBO_AM_IDLE,
    TWBO_AM_DECODE,
    TWBO_AM_ACTIVE,
    TWBO_AM_RELEASE
  } twbo_am_e;

  // decoded memory space
  typedef enum logic [1:0] {
    TWBO_SP_NONE,
    TWBO_SP_CS,
    TWBO_SP_DRAM,
    TWBO_SP_DEFAULT
  } twbo_space_e;

  typedef logic [`TWBO_REGION_W-1:0] twbo_region_t;

  // region match under a don't-care mask
  function automatic logic twbo_region_hit(input twbo_region_t a,
                                           input twbo_region_t base,
                                           input twbo_region_t mask);
    twbo_region_hit = ((a ^ base) & ~mask) == '0;
  endfunction

  // byte lanes touched by an aligned transfer on a 32-bit port
  function automatic logic [`TWBO_NUM_LANES-1:0] twbo_lanes(input logic [1:0] sz,
                                                            input logic [1:0] a);
    case (sz)
      `TWBO_SZ_BYTE: twbo_lanes = 4'h8 >> a;
      `TWBO_SZ_WORD: twbo_lanes = a[1] ? 4'h3 : 4'hc;
      default:       twbo_lanes = 4'hf;
    endcase
  endfunction

endpackage

// File: core/twbo_space_decode.sv
`timescale 1ns/1ps
`include "twbo_cfg.svh"

module twbo_space_decode
  import twbo_pkg::*;
#(
  parameter int NCS = `TWBO_NUM_CS,
  parameter int NDR = `TWBO_NUM_DRAM
) (
  // captured access
  input  wire logic [`TWBO_REGION_W-1:0]      region,
  input  wire logic                           is_read,
  // chip-select regions
  input  wire logic [NCS*`TWBO_REGION_W-1:0]  cs_base,
  input  wire logic [NCS*`TWBO_REGION_W-1:0]  cs_mask,
  input  wire logic [NCS-1:0]                 cs_rd_en,
  input  wire logic [NCS-1:0]                 cs_wr_en,
  // dram banks
  input  wire logic [NDR*`TWBO_REGION_W-1:0]  dr_base,
  input  wire logic [NDR*`TWBO_REGION_W-1:0]  dr_mask,
  input  wire logic [NDR-1:0]                 dr_rd_en,
  input  wire logic [NDR-1:0]                 dr_wr_en,
  // result
  output twbo_space_e                         space,
  output logic [NCS-1:0]                      cs_sel,
  output logic [NDR-1:0]                      dr_sel
);

  logic [NCS-1:0] cs_hit;
  logic [NDR-1:0] dr_hit;

  // per-region match, gated by the enable for this direction
  genvar g;
  generate
    for (g = 0; g < NCS; g++) begin : g_cs
      assign cs_hit[g] = twbo_region_hit(region,
                                         cs_base[g*`TWBO_REGION_W +: `TWBO_REGION_W],
                                         cs_mask[g*`TWBO_REGION_W +: `TWBO_REGION_W])
                         && (is_read ? cs_rd_en[g] : cs_wr_en[g]);
    end
    for (g = 0; g < NDR; g++) begin : g_dr
      assign dr_hit[g] = twbo_region_hit(region,
                                         dr_base[g*`TWBO_REGION_W +: `TWBO_REGION_W],
                                         dr_mask[g*`TWBO_REGION_W +: `TWBO_REGION_W])
                         && (is_read ? dr_rd_en[g] : dr_wr_en[g]);
    end
  endgenerate

  // lowest index wins; chip selects take precedence over dram
  always_comb begin
    cs_sel = '0;
    dr_sel = '0;
    space  = TWBO_SP_DEFAULT;
    for (int i = NDR - 1; i >= 0; i--) begin
      if (dr_hit[i]) begin
        dr_sel = '0;
        dr_sel[i] = 1'b1;
        space = TWBO_SP_DRAM;
      end
    end
    for (int i = NCS - 1; i >= 0; i--) begin
      if (cs_hit[i]) begin
        cs_sel = '0;
        cs_sel[i] = 1'b1;
        space = TWBO_SP_CS;
      end
    end
    if (space == TWBO_SP_CS) begin
      dr_sel = '0;
    end
  end

endmodule

// File: core/twbo_wait_ctr.sv
`timescale 1ns/1ps
`include "twbo_cfg.svh"

module twbo_wait_ctr #(
  parameter int W = `TWBO_WS_W
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst,
  // control
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         clear,
  // status
  output logic              expire_next,
  output logic              running
);

  logic [W-1:0] cnt_reg;
  logic         run_reg;

  // expire_next marks the edge at which the count reaches zero
  assign expire_next = load ? (load_val == '0) : (run_reg && cnt_reg == W'(1));
  assign running     = run_reg;

  // down counter, stops at zero
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
    end else if (clear) begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
    end else if (load) begin
      cnt_reg <= load_val;
      run_reg <= load_val != '0;
    end else if (run_reg) begin
      cnt_reg <= cnt_reg - W'(1);
      run_reg <= cnt_reg != W'(1);
    end
  end

endmodule

// File: core/twbo_arbiter.sv
`timescale 1ns/1ps
`include "twbo_cfg.svh"

// Notes on behaviour
// - reset pin or watchdog reset forces reset state and holds it there.
// - leaving reset: grant asserted goes implicit, else external master owns.
// - implicit: bus undriven; grant lost to external; lock or request to explicit.
// - external owns: wait for grant, then explicit on lock/request, else implicit.
// - explicit held by grant or lock; otherwise release at end of transfer.
// - bus driven and bus-driven asserted only in explicit; owner in two states.
// - bus request output is internal request registered while grant and driven negated.
// - any termination ends a cycle; burst-inhibited series counts as one transfer.
// - a transfer may start on the edge after grant is asserted.
// - with external owner, no shared-bus drive; memory controls and ack still allowed.
// - on transfer start capture 28-bit address, direction and two-bit size.
// - upper four address bits read as zero when those pins are not address.
// - transfer type, access mode and privilege mask bits ignored for external master.
// - decode captured access and start memory control on the next edge.
// - chip-select hit: assert select and write enables; ack if region auto-acks.
// - no address drive for chip-select or default space; master drives it.
// - dram hit: assert dram controls, drive multiplexed address, ack if the bank's ack enable is set.
// - no hit: ack after programmed waits only when default auto-ack set.
module twbo_arbiter
  import twbo_pkg::*;
#(
  parameter int NCS = `TWBO_NUM_CS,
  parameter int NDR = `TWBO_NUM_DRAM,
  parameter int WSW = `TWBO_WS_W
) (
  // clock and reset
  input  wire logic                          ref_clk,
  input  wire logic                          rst,
  // reset sources
  input  wire logic                          reset_in_pin_n,
  input  wire logic                          watchdog_reset,
  // arbitration pins
  input  wire logic                          bus_grant_n,
  output logic                               bus_request_out_n,
  output logic                               bus_driven_n,
  // core side
  input  wire logic                          internal_bus_request,
  input  wire logic                          bus_lock,
  input  wire logic                          xfer_in_progress,
  input  wire logic                          xfer_term,
  input  wire logic                          xfer_err,
  input  wire logic                          xfer_last,
  output logic                               bus_drive_en,
  output logic                               bus_owner,
  output logic                               xfer_start_ok,
  // alternate master bus
  input  wire logic                          transfer_start_n,
  input  wire logic [`TWBO_ADDR_W-1:0]       ext_addr,
  input  wire logic                          ext_read,
  input  wire logic [`TWBO_SIZE_W-1:0]       transfer_size,
  input  wire logic                          transfer_ack_in,
  output logic                               transfer_ack_o,
  output logic                               transfer_ack_oe,
  // configuration
  input  wire logic                          upper_pins_are_addr,
  input  wire logic                          external_master_auto_ack,
  input  wire logic [WSW-1:0]                wait_state_count,
  input  wire logic [NCS*`TWBO_REGION_W-1:0] cs_base,
  input  wire logic [NCS*`TWBO_REGION_W-1:0] chip_select_mask,
  input  wire logic [NCS-1:0]                cs_read_en,
  input  wire logic [NCS-1:0]                cs_write_en,
  input  wire logic [NCS-1:0]                cs_auto_ack,
  input  wire logic [NCS*WSW-1:0]            cs_wait,
  input  wire logic [NDR*`TWBO_REGION_W-1:0] dram_base,
  input  wire logic [NDR*`TWBO_REGION_W-1:0] dram_mask,
  input  wire logic [NDR-1:0]                dram_read_en,
  input  wire logic [NDR-1:0]                dram_write_en,
  input  wire logic [NDR-1:0]                dram_ext_master_ack,
  // memory control
  output logic [NCS-1:0]                     chip_select_n,
  output logic [`TWBO_NUM_LANES-1:0]         write_enable_n,
  output logic [NDR-1:0]                     ras_n,
  output logic [`TWBO_NUM_LANES-1:0]         cas_n,
  output logic                               dram_write_n,
  output logic [`TWBO_DRAM_ADDR_W-1:0]       dram_addr,
  output logic                               dram_addr_oe,
  // status
  output twbo_arb_e                          arb_state
);

  twbo_arb_e                     arb_reg;
  twbo_arb_e                     arb_next;
  twbo_am_e                      am_reg;
  twbo_am_e                      am_next;
  logic                          grant;
  logic                          reset_hold;
  logic                          cycle_end;
  logic                          grant_seen_reg;
  logic [`TWBO_ADDR_W-1:0]       cap_addr_reg;
  logic                          cap_read_reg;
  logic [`TWBO_SIZE_W-1:0]       cap_size_reg;
  twbo_space_e                   dec_space;
  logic [NCS-1:0]                dec_cs;
  logic [NDR-1:0]                dec_dr;
  twbo_space_e                   space_reg;
  logic [NCS-1:0]                cs_sel_reg;
  logic [NDR-1:0]                dr_sel_reg;
  logic                          auto_ack_reg;
  logic                          ack_now;
  logic [WSW-1:0]                sel_wait;
  logic                          sel_ack;
  logic                          ctr_load;
  logic                          ctr_expire;
  logic                          ctr_run;
  logic                          ack_reg;
  logic                          ack_oe_reg;
  logic                          col_phase_reg;
  logic                          ts_taken;

  assign grant      = ~bus_grant_n;
  assign reset_hold = ~reset_in_pin_n | watchdog_reset;
  // error and normal termination both end the cycle; only the last beat
  // of a burst-inhibited series counts
  assign cycle_end  = (xfer_term | xfer_err) & xfer_last;

  // arbitration next state
  always_comb begin
    arb_next = arb_reg;
    if (reset_hold) begin
      arb_next = TWBO_RESET;
    end else begin
      case (arb_reg)
        TWBO_RESET: begin
          arb_next = grant ? TWBO_IMPLICIT : TWBO_EM_OWN;
        end
        TWBO_IMPLICIT: begin
          if (!grant) begin
            arb_next = TWBO_EM_OWN;
          end else if (bus_lock || internal_bus_request) begin
            arb_next = TWBO_EXPLICIT;
          end
        end
        TWBO_EXPLICIT: begin
          // lock keeps us owner even with grant removed
          if (!grant && !bus_lock) begin
            if (!xfer_in_progress || cycle_end) begin
              arb_next = TWBO_EM_OWN;
            end
          end
        end
        TWBO_EM_OWN: begin
          if (grant) begin
            arb_next = (bus_lock || internal_bus_request) ? TWBO_EXPLICIT
                                                          : TWBO_IMPLICIT;
          end
        end
        default: arb_next = TWBO_RESET;
      endcase
    end
  end

  // arbitration state register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      arb_reg <= TWBO_RESET;
    end else begin
      arb_reg <= arb_next;
    end
  end

  // ownership outputs decode straight from the state flop
  assign bus_driven_n = arb_reg != TWBO_EXPLICIT;
  assign bus_drive_en = arb_reg == TWBO_EXPLICIT;
  assign bus_owner    = (arb_reg == TWBO_EXPLICIT) ||
                        (arb_reg == TWBO_IMPLICIT);
  assign arb_state    = arb_reg;

  // request pin only follows the core while the bus is idle to us
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bus_request_out_n <= 1'b1;
    end else if (bus_grant_n && bus_driven_n) begin
      bus_request_out_n <= ~internal_bus_request;
    end
  end

  // grant must have been seen on the previous edge before a start;
  // the arbiter is trusted to grant only a free bus
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      grant_seen_reg <= 1'b0;
    end else begin
      grant_seen_reg <= grant && !reset_hold;
    end
  end
  assign xfer_start_ok = grant_seen_reg && grant &&
                         (arb_reg != TWBO_RESET);

  // a start seen while we do not drive belongs to another master;
  // the recommendation to hold start quiet then is the system's concern
  assign ts_taken = !transfer_start_n && bus_driven_n &&
                    (am_reg == TWBO_AM_IDLE);

  // capture the alternate master address phase
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cap_addr_reg <= '0;
      cap_read_reg <= 1'b1;
      cap_size_reg <= `TWBO_SZ_LONG;
    end else if (ts_taken) begin
      cap_addr_reg <= ext_addr;
      cap_read_reg <= ext_read;
      cap_size_reg <= transfer_size;
      if (!upper_pins_are_addr) begin
        cap_addr_reg[`TWBO_UPPER_MSB:`TWBO_UPPER_LSB] <= `TWBO_UPPER_ZERO;
      end
    end
  end

  // decode uses only address and direction: type, mode and privilege
  // masks have no input here at all
  twbo_space_decode #(
    .NCS (NCS),
    .NDR (NDR)
  ) u_decode (
    .region   (cap_addr_reg[`TWBO_REGION_LSB +: `TWBO_REGION_W]),
    .is_read  (cap_read_reg),
    .cs_base  (cs_base),
    .cs_mask  (chip_select_mask),
    .cs_rd_en (cs_read_en),
    .cs_wr_en (cs_write_en),
    .dr_base  (dram_base),
    .dr_mask  (dram_mask),
    .dr_rd_en (dram_read_en),
    .dr_wr_en (dram_write_en),
    .space    (dec_space),
    .cs_sel   (dec_cs),
    .dr_sel   (dec_dr)
  );

  // wait count and acknowledge enable for the decoded space
  always_comb begin
    sel_wait = wait_state_count;
    sel_ack  = external_master_auto_ack;
    for (int i = 0; i < NCS; i++) begin
      if (dec_cs[i]) begin
        sel_wait = cs_wait[i*WSW +: WSW];
        sel_ack  = cs_auto_ack[i];
      end
    end
    if (dec_space == TWBO_SP_DRAM) begin
      sel_wait = WSW'(`TWBO_DRAM_WAIT);
      sel_ack  = |(dec_dr & dram_ext_master_ack);
    end
  end

  // alternate master access sequence
  always_comb begin
    am_next = am_reg;
    case (am_reg)
      TWBO_AM_IDLE: begin
        if (ts_taken) begin
          am_next = TWBO_AM_DECODE;
        end
      end
      TWBO_AM_DECODE: begin
        am_next = TWBO_AM_ACTIVE;
      end
      TWBO_AM_ACTIVE: begin
        // another slave's ack also closes the access
        if (ack_reg || transfer_ack_in) begin
          am_next = TWBO_AM_RELEASE;
        end
      end
      TWBO_AM_RELEASE: begin
        am_next = TWBO_AM_IDLE;
      end
      default: am_next = TWBO_AM_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      am_reg <= TWBO_AM_IDLE;
    end else begin
      am_reg <= am_next;
    end
  end

  // hold the decode result for the whole access
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      space_reg    <= TWBO_SP_NONE;
      cs_sel_reg   <= '0;
      dr_sel_reg   <= '0;
      auto_ack_reg <= 1'b0;
    end else if (am_reg == TWBO_AM_DECODE) begin
      space_reg    <= dec_space;
      cs_sel_reg   <= dec_cs;
      dr_sel_reg   <= dec_dr;
      auto_ack_reg <= sel_ack;
    end else if (am_reg == TWBO_AM_RELEASE) begin
      space_reg    <= TWBO_SP_NONE;
      cs_sel_reg   <= '0;
      dr_sel_reg   <= '0;
      auto_ack_reg <= 1'b0;
    end
  end

  // wait counter starts one clock after capture
  assign ctr_load = am_reg == TWBO_AM_DECODE;

  twbo_wait_ctr #(
    .W (WSW)
  ) u_wait (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .load        (ctr_load),
    .load_val    (sel_wait),
    .clear       (am_reg == TWBO_AM_RELEASE),
    .expire_next (ctr_expire),
    .running     (ctr_run)
  );

  // zero waits gives ack at the first active edge
  assign ack_now = ctr_load ? (sel_ack && ctr_expire)
                            : (am_reg == TWBO_AM_ACTIVE && auto_ack_reg &&
                               ctr_expire && ctr_run);

  // ack is driven negated while counting, asserted for one clock, then
  // driven negated one more clock before release to avoid a floating edge
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ack_reg    <= 1'b0;
      ack_oe_reg <= 1'b0;
    end else begin
      ack_reg <= ack_now;
      if (am_reg == TWBO_AM_DECODE) begin
        ack_oe_reg <= sel_ack;
      end else if (am_reg == TWBO_AM_RELEASE || am_reg == TWBO_AM_IDLE) begin
        ack_oe_reg <= 1'b0;
      end
    end
  end
  assign transfer_ack_o  = ack_reg;
  assign transfer_ack_oe = ack_oe_reg;

  // chip select and byte write enables for the alternate master
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      chip_select_n  <= '1;
      write_enable_n <= '1;
    end else if (am_reg == TWBO_AM_DECODE && dec_space == TWBO_SP_CS) begin
      chip_select_n <= ~dec_cs;
      // alignment is the master's duty, so the lane mask trusts it
      write_enable_n <= cap_read_reg ? '1
                        : ~twbo_lanes(cap_size_reg, cap_addr_reg[1:0]);
    end else if (am_next == TWBO_AM_RELEASE || am_reg == TWBO_AM_IDLE) begin
      chip_select_n  <= '1;
      write_enable_n <= '1;
    end
  end

  // dram strobes: row first, column after a fixed delay
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ras_n         <= '1;
      cas_n         <= '1;
      dram_write_n  <= 1'b1;
      col_phase_reg <= 1'b0;
    end else if (am_reg == TWBO_AM_DECODE && dec_space == TWBO_SP_DRAM) begin
      ras_n         <= ~dec_dr;
      dram_write_n  <= cap_read_reg;
      col_phase_reg <= 1'b0;
    end else if (am_reg == TWBO_AM_ACTIVE && space_reg == TWBO_SP_DRAM) begin
      col_phase_reg <= 1'b1;
      if (col_phase_reg || `TWBO_RCD_CYCLES == 4'h0) begin
        cas_n <= ~twbo_lanes(cap_size_reg, cap_addr_reg[1:0]);
      end
      if (am_next == TWBO_AM_RELEASE) begin
        ras_n        <= '1;
        cas_n        <= '1;
        dram_write_n <= 1'b1;
      end
    end else begin
      ras_n         <= '1;
      cas_n         <= '1;
      dram_write_n  <= 1'b1;
      col_phase_reg <= 1'b0;
    end
  end

  // multiplexed dram address; only dram accesses drive it, never
  // chip-select or default space
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dram_addr    <= '0;
      dram_addr_oe <= 1'b0;
    end else if (am_reg == TWBO_AM_DECODE && dec_space == TWBO_SP_DRAM) begin
      dram_addr    <= cap_addr_reg[`TWBO_ROW_LSB +: `TWBO_DRAM_ADDR_W];
      dram_addr_oe <= 1'b1;
    end else if (am_reg == TWBO_AM_ACTIVE && space_reg == TWBO_SP_DRAM &&
                 am_next != TWBO_AM_RELEASE) begin
      dram_addr    <= cap_addr_reg[`TWBO_COL_LSB +: `TWBO_DRAM_ADDR_W];
      dram_addr_oe <= 1'b1;
    end else begin
      dram_addr_oe <= 1'b0;
    end
  end

endmodule

// File: verification/twbo_far_side.sv
`timescale 1ns/1ps

module twbo_far_side (
  // device side
  input  wire logic        ref_clk,
  input  wire logic        bus_driven_n,
  input  wire logic        transfer_ack_o,
  input  wire logic        transfer_ack_oe,
  // arbiter and alternate master pins
  output logic             bus_grant_n,
  output logic             transfer_start_n,
  output logic [27:0]      ext_addr,
  output logic             ext_read,
  output logic [1:0]       transfer_size,
  output logic             transfer_ack_in
);
  // wired ack: no slave of ours answers, so only the device can
  assign transfer_ack_in = transfer_ack_oe & transfer_ack_o;
  // idle: no grant, no start, long-word size only
  initial {bus_grant_n, transfer_start_n, ext_addr, ext_read, transfer_size} = {2'h3, 31'h0};
  // only called between alternate transfers
  task automatic grant(input logic on);
    @(posedge ref_clk) bus_grant_n <= ~on;
  endtask
  // one start pulse; lines flip once released so stale values never help
  task automatic start(input logic [27:0] a, input logic rd);
    @(posedge ref_clk);
    while (!bus_driven_n) @(posedge ref_clk);
    transfer_start_n <= 1'b0;
    {ext_addr, ext_read} <= {a, rd};
    @(posedge ref_clk);
    transfer_start_n <= 1'b1;
    {ext_addr, ext_read} <= ~{a, rd};
  endtask
endmodule

// File: verification/twbo_arbiter_checker.sv
`timescale 1ns/1ps

module twbo_chk
  import twbo_pkg::*;
(
  // clock and resets
  input wire logic      ref_clk,
  input wire logic      rst,
  input wire logic      reset_in_pin_n,
  input wire logic      watchdog_reset,
  // arbitration
  input wire logic      bus_grant_n,
  input wire logic      bus_request_out_n,
  input wire logic      bus_driven_n,
  input wire logic      bus_lock,
  input wire logic      internal_bus_request,
  input wire logic      bus_drive_en,
  input wire logic      bus_owner,
  input wire logic      transfer_ack_o,
  input wire twbo_arb_e arb_state
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // both reset sources quiet, and a reason to own the bus
  wire run = reset_in_pin_n && !watchdog_reset;
  wire want = bus_lock || internal_bus_request;

  chk_reset_enter: assert property (!run |=> arb_state == TWBO_RESET)
    else $error("reset state not held");
  chk_reset_leave: assert property (run && arb_state == TWBO_RESET |=>
    arb_state == ($past(bus_grant_n) ? TWBO_EM_OWN : TWBO_IMPLICIT))
    else $error("wrong exit from reset");
  chk_implicit_move: assert property (run && arb_state == TWBO_IMPLICIT |=>
    arb_state == ($past(bus_grant_n) ? TWBO_EM_OWN : $past(want) ? TWBO_EXPLICIT : TWBO_IMPLICIT))
    else $error("wrong move from implicit");
  chk_em_grant: assert property (run && arb_state == TWBO_EM_OWN && !bus_grant_n |=>
    arb_state == ($past(want) ? TWBO_EXPLICIT : TWBO_IMPLICIT))
    else $error("wrong move on grant");
  chk_explicit_hold: assert property (run && arb_state == TWBO_EXPLICIT && want
    && bus_lock || run && arb_state == TWBO_EXPLICIT && !bus_grant_n |=> arb_state == TWBO_EXPLICIT)
    else $error("explicit ownership dropped");
  chk_drive_state: assert property (bus_drive_en == (arb_state == TWBO_EXPLICIT)
    && bus_driven_n == !bus_drive_en) else $error("bus drive outside explicit");
  chk_owner_state: assert property (bus_owner == (arb_state inside {TWBO_IMPLICIT,
    TWBO_EXPLICIT})) else $error("owner flag wrong");
  chk_req_hold: assert property (!bus_grant_n || !bus_driven_n |=>
    $stable(bus_request_out_n)) else $error("request pin moved while frozen");
  chk_ack_pulse: assert property (transfer_ack_o |=> !transfer_ack_o)
    else $error("ack held past one cycle");

  // main scenarios reached
  cover property (arb_state == TWBO_EXPLICIT && bus_grant_n);
  cover property (arb_state == TWBO_IMPLICIT);
  cover property (transfer_ack_o);
endmodule

bind twbo_arbiter twbo_chk chk (.*);

// File: verification/twbo_arbiter_tb.sv
`timescale 1ns/1ps

module twbo_arbiter_tb
  import twbo_pkg::*;
;
  // design inputs, region 0x001 is chip select 0 and 0x300 dram bank 0
  logic ref_clk = 0, rst = 1, reset_in_pin_n = 1, watchdog_reset = 0, bus_lock = 0;
  logic internal_bus_request = 0, xfer_in_progress = 0, xfer_term = 0, xfer_err = 0;
  logic xfer_last = 0, upper_pins_are_addr = 0, external_master_auto_ack = 1;
  logic [3:0]  wait_state_count = 4'h2;
  logic [95:0] cs_base = 96'h1, chip_select_mask = '0;
  logic [7:0]  cs_read_en = 8'h1, cs_write_en = 8'h1, cs_auto_ack = 8'h1;
  logic [31:0] cs_wait = '0;
  logic [23:0] dram_base = 24'h300, dram_mask = '0;
  logic [1:0]  dram_read_en = 2'h1, dram_write_en = 2'h1, dram_ext_master_ack = 2'h1;
  // design and partner outputs
  logic bus_grant_n, bus_request_out_n, bus_driven_n, bus_drive_en, bus_owner, xfer_start_ok;
  logic transfer_start_n, ext_read, transfer_ack_in, transfer_ack_o, transfer_ack_oe;
  logic dram_write_n, dram_addr_oe;
  logic [27:0] ext_addr;
  logic [1:0]  transfer_size, ras_n;
  logic [7:0]  chip_select_n;
  logic [3:0]  write_enable_n, cas_n;
  logic [13:0] dram_addr;
  twbo_arb_e   arb_state;
  int          fails = 0, checks = 0;

  twbo_arbiter uut (.*);
  twbo_far_side fs (.*);

  // 20 MHz clock
  initial forever #25 ref_clk = ~ref_clk;

  task automatic cmp(input string n, input logic [3:0] e, input logic [3:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // look just after an edge so its updates have landed
  task automatic settle;
    @(posedge ref_clk) #1;
  endtask
  task automatic end_of_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // granted with a request, grant lost mid transfer, freed on the last beat
  task automatic t_explicit;
    @(posedge ref_clk) internal_bus_request <= 1'b1;
    settle;
    cmp("req", 4'h0, bus_request_out_n);
    fs.grant(1'b1);
    xfer_in_progress <= 1'b1;
    settle;
    cmp("state", TWBO_EXPLICIT, arb_state);
    cmp("bd", 4'h0, bus_driven_n);
    cmp("ok", 4'h1, xfer_start_ok);
    fs.grant(1'b0);
    internal_bus_request <= 1'b0;
    settle;
    cmp("state", TWBO_EXPLICIT, arb_state);
    cmp("req", 4'h0, bus_request_out_n);
    @(posedge ref_clk) xfer_term <= 1'b1;
    @(posedge ref_clk) {xfer_term, xfer_err, xfer_last} <= 3'h3;
    #1 cmp("state", TWBO_EXPLICIT, arb_state);
    @(posedge ref_clk) {xfer_err, xfer_last, xfer_in_progress} <= 3'h0;
    #1 cmp("state", TWBO_EM_OWN, arb_state);
    settle;
    cmp("bd", 4'h1, bus_driven_n);
    cmp("req", 4'h1, bus_request_out_n);
  endtask
  // lock takes explicit from implicit and keeps it without grant
  task automatic t_lock;
    fs.grant(1'b1);
    settle;
    cmp("state", TWBO_IMPLICIT, arb_state);
    cmp("own", 4'h1, bus_owner);
    @(posedge ref_clk) bus_lock <= 1'b1;
    settle;
    cmp("state", TWBO_EXPLICIT, arb_state);
    fs.grant(1'b0);
    settle;
    cmp("state", TWBO_EXPLICIT, arb_state);
    @(posedge ref_clk) bus_lock <= 1'b0;
    settle;
    cmp("state", TWBO_EM_OWN, arb_state);
  endtask
  // reset pin or watchdog holds reset; exit follows grant
  task automatic t_reset(input logic pin);
    fs.grant(pin);
    {reset_in_pin_n, watchdog_reset} <= pin ? 2'h0 : 2'h3;
    repeat (2) settle;
    cmp("state", TWBO_RESET, arb_state);
    @(posedge ref_clk) {reset_in_pin_n, watchdog_reset} <= 2'h2;
    settle;
    cmp("state", pin ? TWBO_IMPLICIT : TWBO_EM_OWN, arb_state);
  endtask
  // one alternate master access, a write for k 1; k: 0 default, 1 chip select, 2 dram
  task automatic t_access(input logic [27:0] a, input int w, input int k);
    fs.start(a, k != 1);
    settle;
    cmp("cs", 4'(k != 1), chip_select_n[0]);
    cmp("we", k == 1 ? 4'h0 : 4'hf, write_enable_n);
    cmp("ras", 4'(k != 2), ras_n[0]);
    if (k != 2) cmp("aoe", 4'h0, dram_addr_oe);
    cmp("ack", 4'(w == 0), transfer_ack_o);
    repeat (w) settle;
    cmp("ack", 4'h1, transfer_ack_o);
    settle;
    cmp("oe", 4'h1, transfer_ack_oe);
    settle;
    cmp("oe", 4'h0, transfer_ack_oe);
  endtask

  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    t_explicit;
    t_lock;
    t_reset(1'b1);
    t_reset(1'b0);
    t_access(28'h2000000, 2, 0);
    t_access(28'hf010000, 0, 1);
    @(posedge ref_clk) upper_pins_are_addr <= 1'b1;
    t_access(28'h3000000, 2, 2);
    end_of_test;
  end
  // hang guard, 2000 cycles, far beyond the few dozen cycles needed
  initial begin
    #100us;
    fails++;
    end_of_test;
  end
endmodule
